// ===== apm_clk_div.sv
// programmable clock-enable divider, held in pass-through while stopped
`timescale 1ns/1ps
module apm_clk_div #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         run,
  input  wire logic         in_en,
  input  wire logic [W-1:0] ratio,
  output logic              out_en
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg <= '0;
    end else if (in_en) begin
      cnt_reg <= (cnt_reg >= ratio) ? '0 : W'(cnt_reg + 1'b1);
    end
  end

  // stopped divider passes its input as divide-by-1
  assign out_en = in_en && (!run || cnt_reg >= ratio);
endmodule

// ===== apm_ctrl.sv
// receive reset/enable control and mute driver with AXI4-Lite registers
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "apm_map.svh"
module apm_ctrl #(
  parameter int SLOT_W  = 5,
  parameter int FRAME_W = 8
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`APM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`APM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   aux_clk_en,
  input  wire logic                   rx_fsync_in,
  input  wire logic                   tx_dma_err,
  input  wire logic                   rx_dma_err,
  input  wire logic                   tx_clk_fail,
  input  wire logic                   rx_clk_fail,
  input  wire logic                   tx_sync_err,
  input  wire logic                   rx_sync_err,
  input  wire logic                   tx_underrun,
  input  wire logic                   rx_overrun,
  input  wire logic                   ext_mute_input,
  output logic                        mute_output_pin_o,
  output logic                        mute_output_pin_oe_n,
  output logic                        rx_hf_clk_en,
  output logic                        rx_bit_clk_en,
  output logic                        rx_fsync_out,
  output logic                        rx_sm_running,
  output logic [SLOT_W-1:0]           rx_slot,
  output logic                        rx_slot_start,
  output logic                        rx_serializer_clear,
  output logic                        irq
);
  logic [`APM_GBL_W-1:0] gbl_reg;
  logic [12:0]           mute_reg;
  logic [`APM_IRQ_W-1:0] status_reg;
  logic [`APM_IRQ_W-1:0] mask_reg;
  logic [7:0]            hf_ratio_reg;
  logic [7:0]            bit_ratio_reg;
  logic [FRAME_W-1:0]    frame_len_reg;
  logic [SLOT_W-1:0]     slot_bits_reg;

  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [`APM_ADDR_W-1:0] awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  wr_fire;
  logic                  wr_hit;

  logic [2:0]            in_sync_reg;
  logic                  ext_level_reg;
  logic                  mute_input_status;
  logic [`APM_ERR_W-1:0] err_vec;
  logic [`APM_ERR_W-1:0] err_en;
  logic                  mute_active;
  logic                  ser_prev_reg;
  logic                  flush_pulse;
  logic [`APM_IRQ_W-1:0] irq_events;

  logic [FRAME_W-1:0]    fs_cnt_reg;
  logic [SLOT_W-1:0]     bit_cnt_reg;
  logic [SLOT_W-1:0]     slot_reg;
  logic                  fsync_prev_reg;
  logic                  fsync_edge;
  logic                  slot_start_reg;
  apm_pkg::apm_rx_state_t rx_state_reg;
  apm_pkg::apm_rx_state_t rx_state_next;

  // ---------------- AXI4-Lite write channel ----------------
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (awaddr_reg)
      `APM_OFF_GLOBAL, `APM_OFF_MUTECTL, `APM_OFF_STATUS,
      `APM_OFF_IRQ_MASK, `APM_OFF_RX_SLOT, `APM_OFF_DIV_CFG: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `APM_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `APM_RESP_OKAY : `APM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- register writes ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gbl_reg <= `APM_GBL_RESET;
    end else if (wr_fire && awaddr_reg == `APM_OFF_GLOBAL && wstrb_reg[0]) begin
      gbl_reg <= wdata_reg[`APM_GBL_W-1:0];
    end
  end

  // status bit is read-only; stored bits 12..5 and 3..0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute_reg <= `APM_MUTE_RESET;
    end else if (wr_fire && awaddr_reg == `APM_OFF_MUTECTL) begin
      if (wstrb_reg[0]) begin
        mute_reg[7:5] <= wdata_reg[7:5];
        mute_reg[3:0] <= wdata_reg[3:0];
      end
      if (wstrb_reg[1]) begin
        mute_reg[12:8] <= wdata_reg[12:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= '0;
    end else if (wr_fire && awaddr_reg == `APM_OFF_IRQ_MASK) begin
      if (wstrb_reg[0]) mask_reg[7:0] <= wdata_reg[7:0];
      if (wstrb_reg[1]) mask_reg[8] <= wdata_reg[8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_ratio_reg  <= `APM_HF_DIV_RESET;
      bit_ratio_reg <= `APM_BIT_DIV_RESET;
    end else if (wr_fire && awaddr_reg == `APM_OFF_DIV_CFG) begin
      if (wstrb_reg[0]) hf_ratio_reg <= wdata_reg[7:0];
      if (wstrb_reg[1]) bit_ratio_reg <= wdata_reg[15:8];
    end
  end

  // frame length in bit clocks and bits per slot, each stored as the count minus one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_len_reg <= {FRAME_W{1'b1}};
      slot_bits_reg <= {SLOT_W{1'b1}};
    end else if (wr_fire && awaddr_reg == `APM_OFF_RX_SLOT) begin
      if (wstrb_reg[0]) frame_len_reg <= wdata_reg[FRAME_W-1:0];
      if (wstrb_reg[1]) slot_bits_reg <= wdata_reg[8 +: SLOT_W];
    end
  end

  // ---------------- sticky status, set wins over clear ----------------
  assign irq_events = {flush_pulse, err_vec};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < `APM_IRQ_W; i++) begin
        if (irq_events[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wr_fire && awaddr_reg == `APM_OFF_STATUS
                     && wstrb_reg[i/8] && wdata_reg[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ---------------- AXI4-Lite read channel ----------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `APM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `APM_RESP_OKAY;
      unique case (s_axi_araddr)
        `APM_OFF_GLOBAL:   s_axi_rdata <= {27'h0000000, gbl_reg};
        // readback follows live input status
        `APM_OFF_MUTECTL:  s_axi_rdata <= {19'h00000, mute_reg[12:5],
                                           mute_input_status, mute_reg[3:0]};
        `APM_OFF_STATUS:   s_axi_rdata <= {23'h000000, status_reg};
        `APM_OFF_IRQ_MASK: s_axi_rdata <= {23'h000000, mask_reg};
        `APM_OFF_RX_SLOT:  s_axi_rdata <= {32'(slot_reg) << 16}
                                          | {24'h000000, frame_len_reg};
        `APM_OFF_DIV_CFG:  s_axi_rdata <= {16'h0000, bit_ratio_reg, hf_ratio_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `APM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- clock dividers ----------------
  apm_clk_div #(.W(8)) u_hf_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (gbl_reg[`APM_GBL_HF]),
    .in_en   (aux_clk_en),
    .ratio   (hf_ratio_reg),
    .out_en  (rx_hf_clk_en)
  );

  apm_clk_div #(.W(8)) u_bit_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (gbl_reg[`APM_GBL_BIT]),
    .in_en   (rx_hf_clk_en),
    .ratio   (bit_ratio_reg),
    .out_en  (rx_bit_clk_en)
  );

  // ---------------- frame sync generator ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !gbl_reg[`APM_GBL_FSYNC]) begin
      fs_cnt_reg   <= '0;
      rx_fsync_out <= 1'b0;
    end else if (rx_bit_clk_en) begin
      fs_cnt_reg   <= (fs_cnt_reg >= frame_len_reg) ? '0 : FRAME_W'(fs_cnt_reg + 1'b1);
      rx_fsync_out <= (fs_cnt_reg == '0);
    end
  end

  // ---------------- receive state machine ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fsync_prev_reg <= 1'b0;
    end else if (rx_bit_clk_en) begin
      fsync_prev_reg <= rx_fsync_in;
    end
  end

  assign fsync_edge = rx_bit_clk_en && rx_fsync_in && !fsync_prev_reg;

  always_comb begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      apm_pkg::APM_RX_RESET: rx_state_next = apm_pkg::APM_RX_HUNT;
      apm_pkg::APM_RX_HUNT:  if (fsync_edge) rx_state_next = apm_pkg::APM_RX_SLOT;
      apm_pkg::APM_RX_SLOT:  rx_state_next = apm_pkg::APM_RX_SLOT;
      default:               rx_state_next = apm_pkg::APM_RX_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !gbl_reg[`APM_GBL_SM]) begin
      rx_state_reg <= apm_pkg::APM_RX_RESET;
    end else begin
      rx_state_reg <= rx_state_next;
    end
  end

  assign rx_sm_running = (rx_state_reg != apm_pkg::APM_RX_RESET);

  // slot counter restarts at zero on release and each frame sync
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_state_reg == apm_pkg::APM_RX_RESET) begin
      slot_reg       <= '0;
      bit_cnt_reg    <= '0;
      slot_start_reg <= 1'b0;
    end else if (fsync_edge) begin
      slot_reg       <= '0;
      bit_cnt_reg    <= '0;
      slot_start_reg <= 1'b1;
    end else if (rx_state_reg == apm_pkg::APM_RX_SLOT && rx_bit_clk_en) begin
      if (bit_cnt_reg >= slot_bits_reg) begin
        bit_cnt_reg    <= '0;
        slot_reg       <= SLOT_W'(slot_reg + 1'b1);
        slot_start_reg <= 1'b1;
      end else begin
        bit_cnt_reg    <= SLOT_W'(bit_cnt_reg + 1'b1);
        slot_start_reg <= 1'b0;
      end
    end else begin
      slot_start_reg <= 1'b0;
    end
  end

  assign rx_slot       = slot_reg;
  assign rx_slot_start = slot_start_reg;

  // ---------------- serializer clear and flush ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_prev_reg <= 1'b0;
    end else begin
      ser_prev_reg <= gbl_reg[`APM_GBL_SER];
    end
  end

  // rising edge of the enable flushes the receive buffer
  assign flush_pulse         = gbl_reg[`APM_GBL_SER] && !ser_prev_reg;
  assign rx_serializer_clear = !gbl_reg[`APM_GBL_SER] || flush_pulse;

  // ---------------- mute input synchroniser ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sync_reg   <= 3'h0;
      ext_level_reg <= 1'b0;
    end else begin
      in_sync_reg <= {in_sync_reg[1:0], ext_mute_input};
      if (in_sync_reg[1] == in_sync_reg[2]) begin
        ext_level_reg <= in_sync_reg[2];
      end
    end
  end

  assign mute_input_status = ext_level_reg ^ mute_reg[`APM_MUTE_IN_POL];

  // ---------------- mute driver ----------------
  assign err_vec = {tx_dma_err, rx_dma_err, tx_clk_fail, rx_clk_fail,
                    tx_sync_err, rx_sync_err, tx_underrun, rx_overrun};
  // bits 12..5 line up with err_vec
  assign err_en = mute_reg[`APM_MUTE_TXDMA:`APM_MUTE_RXOVR];

  assign mute_active = |(err_vec & err_en)
                     || (mute_input_status && mute_reg[`APM_MUTE_IN_DRIVE]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute_output_pin_o    <= 1'b0;
      mute_output_pin_oe_n <= 1'b1;
    end else begin
      unique case (mute_reg[1:0])
        `APM_MODE_HIGH: begin
          mute_output_pin_o    <= mute_active;
          mute_output_pin_oe_n <= 1'b0;
        end
        `APM_MODE_LOW: begin
          mute_output_pin_o    <= !mute_active;
          mute_output_pin_oe_n <= 1'b0;
        end
        default: begin
          mute_output_pin_o    <= 1'b0;
          mute_output_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ===== apm_ctrl_assertions.sv
// concurrent checks on the receive control and mute block ports
`timescale 1ns/1ps
module apm_ctrl_assertions #(
  parameter int SLOT_W = 5
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [7:0]        s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              aux_clk_en,
  input wire logic              tx_dma_err,
  input wire logic              rx_dma_err,
  input wire logic              tx_clk_fail,
  input wire logic              rx_clk_fail,
  input wire logic              tx_sync_err,
  input wire logic              rx_sync_err,
  input wire logic              tx_underrun,
  input wire logic              rx_overrun,
  input wire logic              mute_output_pin_o,
  input wire logic              mute_output_pin_oe_n,
  input wire logic              rx_hf_clk_en,
  input wire logic              rx_bit_clk_en,
  input wire logic              rx_sm_running,
  input wire logic [SLOT_W-1:0] rx_slot,
  input wire logic              rx_serializer_clear
);
  logic [4:0]  g;
  logic [12:0] m;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [1:0]  md;
  logic        wip, quiet, mute_input_drive_en, act;
  assign quiet = !wip;
  assign md    = m[1:0];
  assign mute_input_drive_en  = m[3];
  assign act   = |(m[12:5] & {tx_dma_err, rx_dma_err, tx_clk_fail, rx_clk_fail,
                              tx_sync_err, rx_sync_err, tx_underrun, rx_overrun});
  // shadow of the two control registers, settled once the write response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wip <= 1'h0;
      wa  <= 8'h00;
      wd  <= 32'h0;
      g   <= 5'h00;
      m   <= 13'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wip <= 1'h1;
        wa  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready) begin
        wip <= 1'h0;
        if (wa == 8'h00) g <= wd[4:0];
        if (wa == 8'h04) m <= wd[12:0];
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hf_pass; quiet && !g[1] |-> rx_hf_clk_en == aux_clk_en; endproperty
  a_hf_pass: assert property (p_hf_pass) else $error("hf divider not in pass-through");
  property p_bit_pass; quiet && !g[0] |-> rx_bit_clk_en == rx_hf_clk_en; endproperty
  a_bit_pass: assert property (p_bit_pass) else $error("bit divider not in pass-through");
  property p_sm_run; quiet |-> rx_sm_running == g[3]; endproperty
  a_sm_run: assert property (p_sm_run) else $error("state machine run differs");
  property p_slot_hold; !rx_sm_running && !$past(rx_sm_running) |-> rx_slot == '0; endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot not zero in reset");
  property p_slot_zero; $rose(rx_sm_running) |-> rx_slot == '0; endproperty
  a_slot_zero: assert property (p_slot_zero) else $error("slot not zero at release");
  property p_ser_clr; quiet && !g[2] |-> rx_serializer_clear; endproperty
  a_ser_clr: assert property (p_ser_clr) else $error("serializers not cleared");
  property p_ser_run; quiet && g[2] && $past(quiet) |-> !rx_serializer_clear; endproperty
  a_ser_run: assert property (p_ser_run) else $error("serializers still cleared");
  property p_mute_oe;
    quiet && $past(quiet) |-> mute_output_pin_oe_n == !($past(md) == 2'h1 || $past(md) == 2'h2);
  endproperty
  a_mute_oe: assert property (p_mute_oe) else $error("mute pin enable wrong");
  property p_mute_lvl;
    quiet && $past(quiet) && !$past(mute_input_drive_en) && !mute_output_pin_oe_n
      |-> mute_output_pin_o == ($past(act) ^ ($past(md) == 2'h2));
  endproperty
  a_mute_lvl: assert property (p_mute_lvl) else $error("mute level wrong");
  property p_mute_on;
    quiet && md == 2'h1 && !mute_input_drive_en && act |=> mute_output_pin_o && !mute_output_pin_oe_n;
  endproperty
  a_mute_on: assert property (p_mute_on) else $error("mute not raised");
endmodule

bind apm_ctrl apm_ctrl_assertions #(.SLOT_W(SLOT_W)) chk (.*);

// ===== apm_ctrl_tb.sv
// self-checking bench for the receive control and mute block
`timescale 1ns/1ps
module apm_ctrl_tb;
  logic        aclk, aresetn, fs_on, act, drv, lv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, en, ev;
  logic [31:0] s_axi_wdata, s_axi_rdata, mk;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        aux_clk_en, rx_fsync_in, ext_mute_input, irq, line;
  logic        tx_dma_err, rx_dma_err, tx_clk_fail, rx_clk_fail;
  logic        tx_sync_err, rx_sync_err, tx_underrun, rx_overrun;
  logic        mute_output_pin_o, mute_output_pin_oe_n, rx_hf_clk_en, rx_bit_clk_en;
  logic        rx_fsync_out, rx_sm_running, rx_slot_start, rx_serializer_clear;
  logic [4:0]  rx_slot;
  logic [33:0] rqe[$];
  logic [31:0] rqm[$];
  logic [1:0]  bq[$];
  int          bad_count = 0;
  int          total_checks = 0;
  logic [31:0] n, h;

  apm_ctrl uut (.*);
  apm_mute_sink far (.pin_o(mute_output_pin_o), .pin_oe_n(mute_output_pin_oe_n), .line(line));

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ta, tw, tb, done;
    done = 1'h0;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      done = tb;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r = 2'h0);
    logic ta, tr, done;
    done = 1'h0;
    rqm.push_back(m);
    rqe.push_back({r, e & m});
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      done = tr;
    end
  endtask

  task automatic set_err(input logic [7:0] v);
    {tx_dma_err, rx_dma_err, tx_clk_fail, rx_clk_fail,
     tx_sync_err, rx_sync_err, tx_underrun, rx_overrun} <= v;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask

  // bus results are matched against the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk_bus({s_axi_bresp, 32'h0}, {bq.pop_front(), 32'h0});
    if (s_axi_rvalid && s_axi_rready) begin
      mk = rqm.pop_front();
      chk_bus({s_axi_rresp, s_axi_rdata & mk}, rqe.pop_front());
    end
  end

  always @(posedge aclk) rx_fsync_in <= fs_on ? 1'($urandom) : 1'h0;

  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    void'($urandom(58369));
    aresetn = 1'h0;
    fs_on = 1'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    aux_clk_en = 1'h1;
    ext_mute_input = 1'h0;
    set_err(8'h00);
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, 32'hFFFFFFFF, 32'h0);
    rd(8'h04, 32'hFFFFFFEF, 32'h0);
    cyc(1);
    chk_val(mute_output_pin_oe_n, 32'h1);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h40, 32'hFFFFFFFF, 2'h2);
    wr(8'h00, 32'hFFFFFFFB);
    cyc(2);
    chk_val({rx_sm_running, rx_slot, rx_serializer_clear}, 32'h41);
    rd(8'h00, 32'hFFFFFFFF, 32'h1B);
    wr(8'h0C, 32'h100);
    wr(8'h00, 32'h1F);
    cyc(2);
    chk_val({rx_serializer_clear, irq}, 32'h1);
    rd(8'h08, 32'h100, 32'h100);
    wr(8'h08, 32'h100);
    cyc(1);
    chk_val(irq, 32'h0);
    wr(8'h00, 32'h1C);
    repeat (16) begin
      @(posedge aclk);
      aux_clk_en <= 1'($urandom);
      @(negedge aclk);
      chk_val({rx_hf_clk_en, rx_bit_clk_en}, {2{aux_clk_en}});
    end
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h1F);
    aux_clk_en <= 1'h1;
    cyc(12);
    n = 0;
    h = 0;
    repeat (36) begin
      @(negedge aclk);
      n += rx_fsync_out;
      h += rx_hf_clk_en;
    end
    chk_val(h, 12);
    chk_val(n, 9);
    fs_on = 1'h1;
    cyc(40);
    fs_on = 1'h0;
    wr(8'h00, 32'h17);
    cyc(1);
    chk_val({rx_sm_running, rx_slot, rx_slot_start}, 32'h0);
    wr(8'h00, 32'h1F);
    cyc(1);
    chk_val({rx_sm_running, rx_slot, rx_slot_start}, 32'h40);
    wr(8'h0C, 32'hFF);
    for (int i = 0; i < 32; i++) begin
      mode = (i < 8) ? 2'h1 : 2'($urandom);
      en = (i < 8) ? 8'h01 << i : 8'($urandom);
      ev = (i < 8) ? 8'h01 << i : 8'($urandom);
      wr(8'h04, {19'h7FFFF, en, 3'h0, mode});
      set_err(ev);
      act = |(en & ev);
      drv = mode == 2'h1 || mode == 2'h2;
      cyc(3);
      chk_val({mute_output_pin_oe_n, line, irq},
              {!drv, drv && (act ^ (mode == 2'h2)), |ev});
      rd(8'h04, 32'hFFFFFFEF, {19'h0, en, 3'h0, mode});
      rd(8'h08, 32'hFF, {24'h0, ev});
      set_err(8'h00);
      wr(8'h08, 32'hFF);
    end
    for (int k = 0; k < 5; k++) begin
      lv = k[1] | k[2];
      wr(8'h04, {28'h0, k < 4, k[0], 2'h1});
      ext_mute_input <= lv;
      cyc(8);
      chk_val(line, (k < 4) && (lv ^ k[0]));
      rd(8'h04, 32'h10, {27'h0, lv ^ k[0], 4'h0});
    end
    cyc(2);
    results();
  end
endmodule

// ===== apm_map.svh
// register map, field positions and reset values of the audio port control block
//
// Behaviour
// - rx_fsync_gen_run low holds receive frame sync generator reset; high lets it count.
// - rx_sm_run low holds receive state machine reset; high starts frame sync search.
// - receive TDM slot count starts at slot zero after state machine release.
// - rx_serializer_active low clears receive serializers; clear then set flushes buffer.
// - rx_hf_divider_run low holds high-frequency divider, passing input undivided.
// - rx_bit_divider_run low holds bit clock divider, passing input divided by one.
// - tx_dma_err_mute_en gates transmit DMA error onto mute output.
// - rx_dma_err_mute_en gates receive DMA error onto mute output.
// - tx_clk_fail_mute_en gates transmit clock failure onto mute output.
// - rx_clk_fail_mute_en gates receive clock failure onto mute output.
// - tx_sync_err_mute_en gates unexpected transmit frame sync onto mute output.
// - rx_sync_err_mute_en gates unexpected receive frame sync onto mute output.
// - tx_underrun_mute_en gates transmit underrun onto mute output.
// - mute control readback reflects pin state, so no constant power-on value.
// - mute_pin_drive_mode: 0 tri-state, 1 drive high on error, 2 low, 3 reserved.
// - rx_overrun_mute_en gates receiver overrun onto mute output.
// - mute_input_polarity picks active level of ext_mute_input for mute_input_status.
// - mute_input_drive_en lets mute_input_status activate the mute output.
`ifndef APM_MAP_SVH
`define APM_MAP_SVH

`define APM_ADDR_W          8
`define APM_OFF_GLOBAL      8'h00
`define APM_OFF_MUTECTL     8'h04
`define APM_OFF_STATUS      8'h08
`define APM_OFF_IRQ_MASK    8'h0C
`define APM_OFF_RX_SLOT     8'h10
`define APM_OFF_DIV_CFG     8'h14

`define APM_GBL_FSYNC       4
`define APM_GBL_SM          3
`define APM_GBL_SER         2
`define APM_GBL_HF          1
`define APM_GBL_BIT         0
`define APM_GBL_W           5
`define APM_GBL_RESET       5'h00

`define APM_MUTE_TXDMA      12
`define APM_MUTE_RXDMA      11
`define APM_MUTE_TXCK       10
`define APM_MUTE_RXCK       9
`define APM_MUTE_TXSYNC     8
`define APM_MUTE_RXSYNC     7
`define APM_MUTE_TXUND      6
`define APM_MUTE_RXOVR      5
`define APM_MUTE_IN_STATUS  4
`define APM_MUTE_IN_DRIVE   3
`define APM_MUTE_IN_POL     2
`define APM_MUTE_MODE_LO    0
`define APM_MUTE_RESET      13'h0000

`define APM_ERR_W           8
`define APM_IRQ_W           9
`define APM_IRQ_FLUSH       8

`define APM_MODE_TRISTATE   2'h0
`define APM_MODE_HIGH       2'h1
`define APM_MODE_LOW        2'h2

`define APM_RESP_OKAY       2'h0
`define APM_RESP_SLVERR     2'h2

`define APM_HF_DIV_RESET    8'h00
`define APM_BIT_DIV_RESET   8'h00

`endif

// ===== apm_mute_sink.sv
// external mute receiver with a pull-down on the mute line
`timescale 1ns/1ps
module apm_mute_sink (
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output logic      line
);
  // released line falls to the pull-down level
  assign line = pin_oe_n ? 1'h0 : pin_o;
endmodule

// ===== apm_pkg.sv
// types of the audio port control block
package apm_pkg;
  typedef enum logic [1:0] {
    APM_RX_RESET,
    APM_RX_HUNT,
    APM_RX_SLOT
  } apm_rx_state_t;
endpackage
